// ===== pkg/salr_defines.svh
`ifndef SALR_DEFINES_SVH
`define SALR_DEFINES_SVH
`define SALR_CRC_POLY 16'h1021
`define SALR_CRC_INIT 16'hffff
`define SALR_RSVD_TOP 40'h0180c20000
`define SALR_RSVD_LAST 8'h2f
`define SALR_BCAST 48'hffffffffffff
`define SALR_MCAST_BIT 40
`endif

// ===== pkg/salr_pkg.sv
package salr_pkg;
  typedef enum logic [2:0] {
    SALR_IDLE = 3'b000,
    SALR_LK_A = 3'b001,
    SALR_LK_B = 3'b010,
    SALR_LN_A = 3'b011,
    SALR_LN_B = 3'b100
  } salr_state_t;
endpackage

// ===== rtl/salr_core.sv
`timescale 1ns/1ps
`include "salr_defines.svh"
`default_nettype none
module salr_core #(
  parameter int PORTS = 9,
  parameter int BKT_BITS = 10
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // Configuration
  input wire logic taggedVlanModeOn,
  input wire logic mcastLearnOn,
  input wire logic ucMissFwdOn,
  input wire logic [PORTS-1:0] ucMissMap,
  input wire logic mcMissFwdOn,
  input wire logic [PORTS-1:0] mcMissMap,
  input wire logic multiportOn,
  input wire logic [47:0] mportAddr0,
  input wire logic [47:0] mportAddr1,
  input wire logic [PORTS-1:0] mportMap0,
  input wire logic [PORTS-1:0] mportMap1,
  input wire logic [PORTS-1:0] rsvdFwdMap,
  input wire logic agePass,
  // Receive header and frame end
  input wire logic hdrValid,
  input wire logic [47:0] hdrSa,
  input wire logic [11:0] hdrVid,
  input wire logic [3:0] hdrPort,
  input wire logic hdrDaReserved,
  input wire logic hdrSaInVlan,
  input wire logic frmEnd,
  input wire logic frmRxOk,
  input wire logic frmLenOk,
  // Lookup request
  input wire logic lkValid,
  input wire logic [47:0] lkDa,
  input wire logic [11:0] lkVid,
  input wire logic [3:0] lkPort,
  // Software entry write
  input wire logic swWrEn,
  input wire logic [BKT_BITS+1:0] swWrIdx,
  input wire logic [47:0] swWrMac,
  input wire logic [11:0] swWrVid,
  input wire logic [PORTS-1:0] swWrFwd,
  input wire logic swWrValid,
  input wire logic swWrStatic,
  input wire logic [2:0] swWrTc,
  // Results
  output logic lkBusy,
  output logic resValid,
  output logic [PORTS-1:0] groupDestPortMask,
  output logic resDrop,
  output logic lookupMiss,
  output logic resReserved,
  output logic [2:0] destTrafficClass,
  output logic resTcValid,
  output logic lrnDone,
  output logic lrnWrote
);
  localparam int ENTRIES = 4 << BKT_BITS;
  localparam logic [PORTS-1:0] ALL_PORTS = {PORTS{1'b1}};

  function automatic logic [15:0] crc16(input logic [47:0] mac, input logic [11:0] vid, input logic useVid);
    logic [59:0] d;
    logic [15:0] c;
    logic fb;
    d = {vid, mac};
    c = `SALR_CRC_INIT;
    for (int i = 59; i >= 0; i--) begin
      if (useVid || i < 48) begin
        fb = c[15] ^ d[i];
        c = {c[14:0], 1'b0};
        if (fb) begin
          c = c ^ `SALR_CRC_POLY;
        end
      end
    end
    return c;
  endfunction

  function automatic logic [PORTS-1:0] onehot(input logic [3:0] p);
    onehot = '0;
    onehot[p] = 1'b1;
  endfunction

  // Table storage
  logic [47:0] tblMac [ENTRIES];
  logic [11:0] tblVid [ENTRIES];
  logic [PORTS-1:0] tblFwd [ENTRIES];
  logic [2:0] tblTc [ENTRIES];
  logic [ENTRIES-1:0] validQ;
  logic [ENTRIES-1:0] staticQ;
  logic [ENTRIES-1:0] recentlyHitQ;

  salr_pkg::salr_state_t stateQ, stateD;
  logic [47:0] kMacQ;
  logic [11:0] kVidQ;
  logic [3:0] kPortQ;
  logic [BKT_BITS-1:0] bktQ;
  logic rsvdQ, mpHitQ;
  logic [PORTS-1:0] mpMapQ;
  logic hitQ, freeQ;
  logic [1:0] hitBinQ, freeBinQ;
  logic [47:0] pSaQ;
  logic [11:0] pVidQ;
  logic [3:0] pPortQ;
  logic pDaRsvdQ, pInVlanQ, lnPendQ;
  logic busyQ, resValidQ, resDropQ, missQ, resRsvdQ, tcValidQ, lrnDoneQ, lrnWroteQ;
  logic [PORTS-1:0] mapQ;
  logic [2:0] tcQ;

  // Two-bin compare for the current half of the bucket
  logic hiHalf;
  logic [BKT_BITS+1:0] idx0, idx1;
  logic m0, m1, f0, f1;
  assign hiHalf = (stateQ == salr_pkg::SALR_LK_B) || (stateQ == salr_pkg::SALR_LN_B);
  assign idx0 = {bktQ, hiHalf, 1'b0};
  assign idx1 = {bktQ, hiHalf, 1'b1};
  assign m0 = validQ[idx0] && tblMac[idx0] == kMacQ && (!taggedVlanModeOn || tblVid[idx0] == kVidQ);
  assign m1 = validQ[idx1] && tblMac[idx1] == kMacQ && (!taggedVlanModeOn || tblVid[idx1] == kVidQ);
  assign f0 = !validQ[idx0];
  assign f1 = !validQ[idx1];

  logic hitAll, freeAll;
  logic [1:0] hitBin, freeBin;
  logic [BKT_BITS+1:0] hitIdx, freeIdx;
  always_comb begin
    hitAll = hitQ || m0 || m1;
    hitBin = hitQ ? hitBinQ : {1'b1, !m0};
    freeAll = freeQ || f0 || f1;
    freeBin = freeQ ? freeBinQ : {1'b1, !f0};
    hitIdx = {bktQ, hitBin};
    freeIdx = {bktQ, freeBin};
  end

  logic lkStart, lnStart, lkDone;
  assign lkStart = stateQ == salr_pkg::SALR_IDLE && lkValid;
  assign lnStart = stateQ == salr_pkg::SALR_IDLE && !lkValid && lnPendQ;
  assign lkDone = stateQ == salr_pkg::SALR_LK_B;

  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      salr_pkg::SALR_IDLE: begin
        if (lkValid) begin
          stateD = salr_pkg::SALR_LK_A;
        end else if (lnPendQ) begin
          stateD = salr_pkg::SALR_LN_A;
        end
      end
      salr_pkg::SALR_LK_A: stateD = salr_pkg::SALR_LK_B;
      salr_pkg::SALR_LK_B: stateD = salr_pkg::SALR_IDLE;
      salr_pkg::SALR_LN_A: stateD = salr_pkg::SALR_LN_B;
      salr_pkg::SALR_LN_B: stateD = salr_pkg::SALR_IDLE;
      default: stateD = salr_pkg::SALR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateQ <= salr_pkg::SALR_IDLE;
      busyQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      busyQ <= stateD != salr_pkg::SALR_IDLE;
    end
  end

  // Captured source info survives until the frame end decision
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pSaQ <= 48'h0;
      pVidQ <= 12'h0;
      pPortQ <= 4'h0;
      pDaRsvdQ <= 1'b0;
      pInVlanQ <= 1'b0;
    end else if (hdrValid) begin
      pSaQ <= hdrSa;
      pVidQ <= hdrVid;
      pPortQ <= hdrPort;
      pDaRsvdQ <= hdrDaReserved;
      pInVlanQ <= hdrSaInVlan;
    end
  end

  // Learn candidate frozen at frame end so a following header cannot leak in
  logic [47:0] lnSaQ;
  logic [11:0] lnVidQ;
  logic [3:0] lnPortQ;
  logic learnable;
  assign learnable = frmRxOk && frmLenOk && !pSaQ[`SALR_MCAST_BIT]
    && (!taggedVlanModeOn || pInVlanQ)
    && (!pDaRsvdQ || mcastLearnOn);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lnPendQ <= 1'b0;
      lnSaQ <= 48'h0;
      lnVidQ <= 12'h0;
      lnPortQ <= 4'h0;
    end else if (frmEnd && learnable) begin
      lnPendQ <= 1'b1;
      lnSaQ <= pSaQ;
      lnVidQ <= pVidQ;
      lnPortQ <= pPortQ;
    end else if (lnStart) begin
      lnPendQ <= 1'b0;
    end
  end

  // Key, bucket pointer and pre-table checks
  logic daMc;
  logic [15:0] lkHash, lnHash;
  assign daMc = kMacQ[`SALR_MCAST_BIT];
  assign lkHash = crc16(lkDa, lkVid, taggedVlanModeOn);
  assign lnHash = crc16(lnSaQ, lnVidQ, taggedVlanModeOn);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      kMacQ <= 48'h0;
      kVidQ <= 12'h0;
      kPortQ <= 4'h0;
      bktQ <= '0;
      rsvdQ <= 1'b0;
      mpHitQ <= 1'b0;
      mpMapQ <= '0;
    end else if (lkStart) begin
      kMacQ <= lkDa;
      kVidQ <= lkVid;
      kPortQ <= lkPort;
      bktQ <= lkHash[BKT_BITS-1:0];
      rsvdQ <= lkDa[47:8] == `SALR_RSVD_TOP && lkDa[7:0] <= `SALR_RSVD_LAST;
      mpHitQ <= multiportOn && (lkDa == mportAddr0 || lkDa == mportAddr1);
      mpMapQ <= lkDa == mportAddr0 ? mportMap0 : mportMap1;
    end else if (lnStart) begin
      kMacQ <= lnSaQ;
      kVidQ <= lnVidQ;
      kPortQ <= lnPortQ;
      bktQ <= lnHash[BKT_BITS-1:0];
      rsvdQ <= 1'b0;
      mpHitQ <= 1'b0;
    end
  end

  // First half results carried into the second cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hitQ <= 1'b0;
      hitBinQ <= 2'h0;
      freeQ <= 1'b0;
      freeBinQ <= 2'h0;
    end else if (stateQ == salr_pkg::SALR_LK_A || stateQ == salr_pkg::SALR_LN_A) begin
      hitQ <= m0 || m1;
      hitBinQ <= {1'b0, !m0};
      freeQ <= f0 || f1;
      freeBinQ <= {1'b0, !f0};
    end
  end

  // Resolution, decided in the second read cycle
  logic ucHit, ucSelf;
  assign ucHit = !daMc && hitAll;
  assign ucSelf = tblFwd[hitIdx][3:0] == kPortQ;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resValidQ <= 1'b0;
      mapQ <= '0;
      resDropQ <= 1'b0;
      missQ <= 1'b0;
      resRsvdQ <= 1'b0;
      tcQ <= 3'h0;
      tcValidQ <= 1'b0;
    end else begin
      resValidQ <= lkDone;
      if (lkDone) begin
        resDropQ <= 1'b0;
        missQ <= 1'b0;
        resRsvdQ <= 1'b0;
        tcValidQ <= 1'b0;
        tcQ <= 3'h0;
        if (daMc && rsvdQ) begin
          resRsvdQ <= 1'b1;
          mapQ <= rsvdFwdMap;
        end else if (mpHitQ) begin
          mapQ <= mpMapQ;
        end else if (kMacQ == `SALR_BCAST) begin
          mapQ <= ALL_PORTS & ~onehot(kPortQ);
        end else if (hitAll) begin
          tcValidQ <= staticQ[hitIdx];
          tcQ <= staticQ[hitIdx] ? tblTc[hitIdx] : 3'h0;
          if (!daMc && ucSelf) begin
            resDropQ <= 1'b1;
            mapQ <= '0;
          end else begin
            mapQ <= daMc ? tblFwd[hitIdx] : onehot(tblFwd[hitIdx][3:0]);
          end
        end else begin
          missQ <= 1'b1;
          if (!daMc && ucMissFwdOn) begin
            mapQ <= ucMissMap;
          end else if (daMc && mcMissFwdOn) begin
            mapQ <= mcMissMap;
          end else begin
            mapQ <= ALL_PORTS & ~onehot(kPortQ);
          end
        end
      end
    end
  end

  // Learn decision; a software write in the same cycle takes the port
  logic lnDone, lnWr, lkTouch;
  logic [BKT_BITS+1:0] lnWrIdx;
  assign lnDone = stateQ == salr_pkg::SALR_LN_B;
  assign lnWr = lnDone && !swWrEn && (hitAll ? !staticQ[hitIdx] : freeAll);
  assign lnWrIdx = hitAll ? hitIdx : freeIdx;
  assign lkTouch = lkDone && hitAll && !(daMc && rsvdQ) && !mpHitQ;

  always_ff @(posedge core_clk) begin
    if (swWrEn) begin
      tblMac[swWrIdx] <= swWrMac;
      tblVid[swWrIdx] <= swWrVid;
      tblFwd[swWrIdx] <= swWrFwd;
      tblTc[swWrIdx] <= swWrTc;
    end else if (lnWr) begin
      tblMac[lnWrIdx] <= kMacQ;
      tblVid[lnWrIdx] <= kVidQ;
      tblFwd[lnWrIdx] <= {{(PORTS-4){1'b0}}, kPortQ};
      tblTc[lnWrIdx] <= 3'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      validQ <= '0;
      staticQ <= '0;
    end else if (swWrEn) begin
      validQ[swWrIdx] <= swWrValid;
      staticQ[swWrIdx] <= swWrStatic;
    end else if (lnWr) begin
      validQ[lnWrIdx] <= 1'b1;
      staticQ[lnWrIdx] <= 1'b0;
    end
  end

  // Aging pass clears only dynamic entries; a hit in that cycle still sets
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      recentlyHitQ <= '0;
    end else begin
      if (agePass) begin
        recentlyHitQ <= recentlyHitQ & staticQ;
      end
      if (lnWr) begin
        recentlyHitQ[lnWrIdx] <= 1'b1;
      end
      if (lkTouch) begin
        recentlyHitQ[hitIdx] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lrnDoneQ <= 1'b0;
      lrnWroteQ <= 1'b0;
    end else begin
      lrnDoneQ <= lnDone;
      lrnWroteQ <= lnWr;
    end
  end

  assign lkBusy = busyQ;
  assign resValid = resValidQ;
  assign groupDestPortMask = mapQ;
  assign resDrop = resDropQ;
  assign lookupMiss = missQ;
  assign resReserved = resRsvdQ;
  assign destTrafficClass = tcQ;
  assign resTcValid = tcValidQ;
  assign lrnDone = lrnDoneQ;
  assign lrnWrote = lrnWroteQ;

  sequence lkSteps;
    stateQ == salr_pkg::SALR_LK_A ##1 stateQ == salr_pkg::SALR_LK_B ##1 resValid;
  endsequence

  a_lookup_steps: assert property (@(posedge core_clk) disable iff (!rst_b)
    lkValid && !lkBusy |=> lkSteps) else $error("lookup sequence broken");
  a_result_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    resValid |=> !resValid) else $error("result held too long");
  a_self_drop: assert property (@(posedge core_clk) disable iff (!rst_b)
    lkDone && !daMc && hitAll && !mpHitQ && ucSelf |=> resDrop && groupDestPortMask == '0)
    else $error("self-port unicast not dropped");
  a_uc_onehot: assert property (@(posedge core_clk) disable iff (!rst_b)
    lkDone && ucHit && !mpHitQ && !ucSelf |=> $onehot(groupDestPortMask) && !lookupMiss)
    else $error("unicast hit not single port");
  a_uc_missmap: assert property (@(posedge core_clk) disable iff (!rst_b)
    lkDone && !daMc && !hitAll && !mpHitQ && kMacQ != `SALR_BCAST && ucMissFwdOn
    |=> groupDestPortMask == $past(ucMissMap)) else $error("unicast miss map ignored");
  a_tc_static: assert property (@(posedge core_clk) disable iff (!rst_b)
    resValid && !resTcValid |-> destTrafficClass == 3'h0) else $error("dynamic entry gave class");
  a_learn_flags: assert property (@(posedge core_clk) disable iff (!rst_b)
    lnWr |=> validQ[$past(lnWrIdx)] && !staticQ[$past(lnWrIdx)] && recentlyHitQ[$past(lnWrIdx)])
    else $error("learned entry flags wrong");
  a_no_mc_learn: assert property (@(posedge core_clk) disable iff (!rst_b)
    stateQ == salr_pkg::SALR_LN_A |-> !kMacQ[`SALR_MCAST_BIT]) else $error("multicast source learned");
  a_learn_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    frmEnd && !frmRxOk && !lnPendQ |=> !lnPendQ) else $error("bad frame queued for learning");
  a_rsvd_first: assert property (@(posedge core_clk) disable iff (!rst_b)
    lkDone && daMc && rsvdQ |=> resReserved && groupDestPortMask == $past(rsvdFwdMap))
    else $error("reserved range not handled first");
endmodule
`default_nettype wire

// ===== verif/salr_ingress_model.sv
`timescale 1ns/1ps
`default_nettype none
module salr_ingress_model (
  // Clock and results
  input wire logic core_clk,
  input wire logic resValid,
  input wire logic lrnDone,
  input wire logic lrnWrote,
  // Lookup request
  output logic lkValid,
  output logic [47:0] lkDa,
  output logic [11:0] lkVid,
  output logic [3:0] lkPort,
  // Header and frame end
  output logic hdrValid,
  output logic [47:0] hdrSa,
  output logic [11:0] hdrVid,
  output logic [3:0] hdrPort,
  output logic hdrDaReserved,
  output logic hdrSaInVlan,
  output logic frmEnd,
  output logic frmRxOk,
  output logic frmLenOk
);
  initial begin
    {lkValid, hdrValid, frmEnd} = 3'h0;
    {lkDa, lkVid, lkPort} = 64'h0;
    {hdrSa, hdrVid, hdrPort, hdrDaReserved, hdrSaInVlan, frmRxOk, frmLenOk} = 68'h0;
  end

  task automatic lookup(input logic [47:0] da, input logic [11:0] vid, input logic [3:0] port, output logic got);
    int n;
    @(negedge core_clk);
    {lkValid, lkDa, lkVid, lkPort} = {1'b1, da, vid, port};
    @(negedge core_clk);
    // Released lines must not echo the request
    {lkValid, lkDa, lkVid} = {1'b0, ~da, ~vid};
    got = 1'b0;
    for (n = 0; n < 6 && !got; n++) begin
      @(posedge core_clk);
      #1 got = (resValid === 1'b1);
    end
    // Return on a falling edge so follow-up stimulus stays off the sampling edge
    @(negedge core_clk);
  endtask

  // Flags: daReserved, saInVlan, rxOk, lenOk
  task automatic learn(input logic [47:0] sa, input logic [11:0] vid, input logic [3:0] port,
      input logic [3:0] flags, output logic done, output logic wrote);
    int n;
    @(negedge core_clk);
    {hdrValid, hdrSa, hdrVid, hdrPort, hdrDaReserved, hdrSaInVlan} = {1'b1, sa, vid, port, flags[3:2]};
    @(negedge core_clk);
    {hdrValid, hdrSa, hdrVid} = {1'b0, ~sa, ~vid};
    @(negedge core_clk);
    {frmEnd, frmRxOk, frmLenOk} = {1'b1, flags[1:0]};
    @(negedge core_clk);
    {frmEnd, frmRxOk, frmLenOk} = {1'b0, ~flags[1:0]};
    done = 1'b0;
    wrote = 1'b0;
    for (n = 0; n < 8 && !done; n++) begin
      @(posedge core_clk);
      #1 done = (lrnDone === 1'b1);
      wrote = (lrnWrote === 1'b1);
    end
    @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// ===== verif/salr_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module salr_core_tb;
  logic core_clk, rst_b, taggedVlanModeOn, mcastLearnOn, ucMissFwdOn, mcMissFwdOn, multiportOn, agePass;
  logic [8:0] ucMissMap, mcMissMap, mportMap0, mportMap1, rsvdFwdMap, swWrFwd, groupDestPortMask;
  logic [47:0] mportAddr0, mportAddr1, hdrSa, lkDa, swWrMac;
  logic [11:0] hdrVid, lkVid, swWrIdx, swWrVid;
  logic [3:0] hdrPort, lkPort;
  logic hdrValid, hdrDaReserved, hdrSaInVlan, frmEnd, frmRxOk, frmLenOk, lkValid;
  logic swWrEn, swWrValid, swWrStatic, lkBusy, resValid, resDrop, lookupMiss, resReserved;
  logic [2:0] swWrTc, destTrafficClass;
  logic resTcValid, lrnDone, lrnWrote, got, done, wrote;
  int mismatches = 0;
  int comparisons = 0;
  localparam logic [47:0] StaA = 48'h001122334455;
  localparam logic [47:0] StaG = 48'h0a0b0c0d0e0f;

  salr_core dut_u (.core_clk, .rst_b, .taggedVlanModeOn, .mcastLearnOn, .ucMissFwdOn, .ucMissMap,
    .mcMissFwdOn, .mcMissMap, .multiportOn, .mportAddr0, .mportAddr1, .mportMap0, .mportMap1,
    .rsvdFwdMap, .agePass, .hdrValid, .hdrSa, .hdrVid, .hdrPort, .hdrDaReserved, .hdrSaInVlan,
    .frmEnd, .frmRxOk, .frmLenOk, .lkValid, .lkDa, .lkVid, .lkPort, .swWrEn, .swWrIdx, .swWrMac,
    .swWrVid, .swWrFwd, .swWrValid, .swWrStatic, .swWrTc, .lkBusy, .resValid, .groupDestPortMask,
    .resDrop, .lookupMiss, .resReserved, .destTrafficClass, .resTcValid, .lrnDone, .lrnWrote);

  salr_ingress_model model_u (.core_clk, .resValid, .lrnDone, .lrnWrote, .lkValid, .lkDa, .lkVid,
    .lkPort, .hdrValid, .hdrSa, .hdrVid, .hdrPort, .hdrDaReserved, .hdrSaInVlan, .frmEnd,
    .frmRxOk, .frmLenOk);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [9:0] bucket_of(input logic [47:0] mac, input logic [11:0] vid, input logic tg);
    logic [15:0] crc;
    logic [59:0] key;
    int i;
    crc = 16'hffff;
    key = {vid, mac};
    for (i = 59; i >= 0; i--) begin
      if (tg || i < 48) begin
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ key[i]) ? 16'h1021 : 16'h0000);
      end
    end
    return crc[9:0];
  endfunction

  task automatic sw_write(input logic [11:0] idx, input logic [47:0] mac, input logic [11:0] vid,
      input logic [8:0] fwd, input logic [2:0] tc);
    @(negedge core_clk);
    {swWrEn, swWrIdx, swWrMac, swWrVid, swWrFwd, swWrValid, swWrStatic, swWrTc} = {1'b1, idx, mac, vid, fwd, 2'b11, tc};
    @(negedge core_clk);
    swWrEn = 1'b0;
  endtask

  task automatic t_learn_hit;
    model_u.learn(StaA, 12'h000, 4'h3, 4'h3, done, wrote);
    `CHK({done, wrote}, 2'b11)
    model_u.lookup(StaA, 12'h000, 4'h5, got);
    `CHK({got, lookupMiss, resDrop, resTcValid}, 4'h8)
    `CHK(groupDestPortMask, 9'h008)
    model_u.lookup(StaA, 12'h000, 4'h3, got);
    `CHK({got, resDrop}, 2'b11)
    model_u.learn(StaA, 12'h000, 4'h6, 4'h3, done, wrote);
    model_u.lookup(StaA, 12'h000, 4'h5, got);
    `CHK({wrote, groupDestPortMask}, {1'b1, 9'h040})
  endtask

  task automatic t_learn_refused;
    logic [3:0] bad [3] = '{4'h1, 4'h2, 4'hb};
    foreach (bad[i]) begin
      model_u.learn(StaG, 12'h000, 4'h1, bad[i], done, wrote);
      `CHK(done, 1'b0)
    end
    model_u.learn(48'h0100aabbccdd, 12'h000, 4'h1, 4'h3, done, wrote);
    `CHK(done, 1'b0)
    mcastLearnOn = 1'b1;
    model_u.learn(StaG, 12'h000, 4'h1, 4'hb, done, wrote);
    `CHK({done, wrote}, 2'b11)
    mcastLearnOn = 1'b0;
  endtask

  task automatic t_miss;
    ucMissFwdOn = 1'b1;
    model_u.lookup(48'h00000000beef, 12'h000, 4'h2, got);
    `CHK({got, lookupMiss, groupDestPortMask}, {2'b11, 9'h0a5})
    ucMissFwdOn = 1'b0;
    model_u.lookup(48'h00000000beef, 12'h000, 4'h2, got);
    `CHK({got, lookupMiss, groupDestPortMask}, {2'b11, 9'h1fb})
    model_u.lookup(48'hffffffffffff, 12'h000, 4'h0, got);
    `CHK({got, groupDestPortMask}, {1'b1, 9'h1fe})
  endtask

  task automatic t_mcast;
    logic [47:0] grp;
    grp = 48'h01005e010203;
    sw_write({bucket_of(grp, 12'h000, 1'b0), 2'b01}, grp, 12'h000, 9'h133, 3'h5);
    model_u.lookup(grp, 12'h000, 4'h0, got);
    `CHK({got, lookupMiss, groupDestPortMask}, {2'b10, 9'h133})
    `CHK({resTcValid, destTrafficClass}, 4'hd)
    mcMissFwdOn = 1'b1;
    model_u.lookup(48'h01005e777777, 12'h000, 4'h0, got);
    `CHK({got, lookupMiss, groupDestPortMask}, {2'b11, 9'h055})
    mcMissFwdOn = 1'b0;
  endtask

  task automatic t_aging;
    logic [11:0] ia, ig;
    ia = {bucket_of(StaA, 12'h000, 1'b0), 2'b00};
    ig = {bucket_of(48'h01005e010203, 12'h000, 1'b0), 2'b01};
    agePass = 1'b1;
    @(negedge core_clk);
    agePass = 1'b0;
    `CHK({dut_u.recentlyHitQ[ia], dut_u.recentlyHitQ[ig]}, 2'b01)
    fork
      model_u.lookup(StaA, 12'h000, 4'h5, got);
      begin
        repeat (2) @(posedge core_clk);
        #1 `CHK(lkBusy, 1'b1)
      end
    join
    `CHK({got, lkBusy, dut_u.recentlyHitQ[ia]}, 3'b101)
  endtask

  task automatic t_special;
    multiportOn = 1'b1;
    mportAddr0 = 48'h0180c2000021;
    model_u.lookup(48'h0180c2000021, 12'h000, 4'h0, got);
    `CHK({got, resReserved, groupDestPortMask}, {2'b11, 9'h10f})
    mportAddr1 = 48'h0180c2000030;
    model_u.lookup(48'h0180c2000030, 12'h000, 4'h0, got);
    `CHK({got, resReserved, groupDestPortMask}, {2'b10, 9'h0c0})
    mportAddr0 = StaA;
    model_u.lookup(StaA, 12'h000, 4'h5, got);
    `CHK({got, groupDestPortMask}, {1'b1, 9'h03c})
    multiportOn = 1'b0;
  endtask

  task automatic t_full_tagged;
    logic [9:0] bkt;
    taggedVlanModeOn = 1'b1;
    bkt = bucket_of(48'h00aa00bb00cc, 12'h007, 1'b1);
    for (int b = 0; b < 4; b++) begin
      sw_write({bkt, 2'(b)}, 48'h00f0f0f0f000 + 48'(b), 12'h001, 9'h001, 3'h0);
    end
    model_u.learn(48'h00aa00bb00cc, 12'h007, 4'h2, 4'h7, done, wrote);
    `CHK({done, wrote}, 2'b10)
    model_u.learn(StaG, 12'h007, 4'h4, 4'h3, done, wrote);
    `CHK(done, 1'b0)
    model_u.learn(StaG, 12'h007, 4'h4, 4'h7, done, wrote);
    `CHK({done, wrote}, 2'b11)
    model_u.lookup(StaG, 12'h008, 4'h0, got);
    `CHK({got, lookupMiss}, 2'b11)
    model_u.lookup(StaG, 12'h007, 4'h0, got);
    `CHK({got, lookupMiss, groupDestPortMask}, {2'b10, 9'h010})
  endtask

  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    {rst_b, taggedVlanModeOn, mcastLearnOn, ucMissFwdOn, mcMissFwdOn, multiportOn, agePass} = 7'h0;
    {ucMissMap, mcMissMap, mportMap0, mportMap1, rsvdFwdMap} = {9'h0a5, 9'h055, 9'h03c, 9'h0c0, 9'h10f};
    {mportAddr0, mportAddr1} = 96'h0;
    {swWrEn, swWrIdx, swWrMac, swWrVid, swWrFwd, swWrValid, swWrStatic, swWrTc} = 87'h0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    t_learn_hit();
    t_learn_refused();
    t_miss();
    t_mcast();
    t_aging();
    t_special();
    t_full_tagged();
    report_and_stop();
  end

  initial begin
    #2000000;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
